// ---- src/call_seq_pkg.sv ----
// package: types and constants for the procedure call sequencer
package call_seq_pkg;
  // ==========================================================================
  // widths and reset values
  localparam int XLEN = 64;
  localparam int STK_AW = 10;
  localparam int NUM_GPR = 8;
  localparam int CNT_W = 5;
  localparam logic [63:0] RST_IP = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RST_SP = 64'h0000_0000_0000_0400;
  localparam logic [15:0] RST_CS = 16'h0003;
  localparam logic [15:0] RST_SS = 16'h000b;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
  localparam logic [1:0] RST_CPL = 2'h3;
  // ==========================================================================
  // register indices in push order
  localparam logic [2:0] GPR_ACC = 3'h0;
  localparam logic [2:0] GPR_SP = 3'h4;
  localparam logic [2:0] GPR_SI = 3'h6;
  localparam logic [2:0] GPR_LAST = 3'h7;
  // ==========================================================================
  // selector requested-ring field and slot sizes in bytes
  localparam int SEL_RING_LSB = 0;
  localparam logic [3:0] SLOT_16 = 4'h2;
  localparam logic [3:0] SLOT_32 = 4'h4;
  localparam logic [3:0] SLOT_64 = 4'h8;
  localparam logic [15:0] FLAGS_LO_MASK = 16'hffff;

  typedef enum logic [1:0] {
    OSZ_16 = 2'h0,
    OSZ_32 = 2'h1,
    OSZ_64 = 2'h2
  } osz_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_SET_GPR = 4'h1, OP_PUSH_ALL = 4'h2, OP_POP_ALL = 4'h3,
    OP_PUSH_FLAGS_WORD_W = 4'h4, OP_PUSH_FLAGS_WORD_D = 4'h5, OP_POP_FLAGS_WORD_W = 4'h6, OP_POP_FLAGS_WORD_D = 4'h7,
    OP_CALL_NEAR = 4'h8, OP_RET_NEAR = 4'h9, OP_CALL_FAR = 4'ha, OP_CALL_GATE = 4'hb,
    OP_RET_FAR = 4'hc, OP_JMP = 4'hd, OP_JCC = 4'he, OP_LOOP = 4'hf
  } op_t;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_PUSH_ALL = 11'h002, ST_POP_RD = 11'h004,
    ST_POP_WB = 11'h008, ST_G_STK = 11'h010, ST_G_CPRD = 11'h020,
    ST_G_CPWR = 11'h040, ST_G_LINK = 11'h080, ST_JUMP_IF_COUNT_ZERO = 11'h100,
    ST_COMMIT = 11'h200, ST_FAULT = 11'h400
  } state_t;

  typedef struct packed {
    op_t op;
    logic [2:0] idx;
    logic indirect;
    logic cond_zero;
    logic osz16;
    logic asz32;
    logic [15:0] n;
    logic [31:0] disp;
    logic [15:0] sel;
    logic [63:0] value;
  } cmd_t;

  typedef struct packed {
    logic [1:0] dpl;
    logic [15:0] cs_sel;
    logic [63:0] offset;
    logic [CNT_W-1:0] pcount;
    logic wide;
  } gate_t;

  typedef struct packed {
    logic [15:0] ss;
    logic [63:0] sp;
  } stk_ptr_t;
endpackage : call_seq_pkg

// ---- src/procedure_call_privilege_sequencer.sv ----
// file: procedure call, return and ring-switch sequencer
`timescale 1ns/100ps
module procedure_call_privilege_sequencer (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire call_seq_pkg::cmd_t i_cmd,
  input wire call_seq_pkg::gate_t i_gate,
  input wire call_seq_pkg::stk_ptr_t [2:0] i_tss_stk,
  input wire logic i_mode64,
  input wire logic i_compat,
  output logic o_ready,
  output logic o_done,
  output logic o_gp_fault,
  output logic [63:0] o_ip,
  output logic [15:0] o_cs,
  output logic [15:0] o_ss,
  output logic [1:0] o_cpl,
  output logic [31:0] o_flags,
  output logic [7:0][63:0] o_gpr
);
  import call_seq_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [63:0] trunc(input logic [63:0] v, input osz_t s);
    case (s)
      OSZ_16: trunc = {48'h0, v[15:0]};
      OSZ_32: trunc = {32'h0, v[31:0]};
      default: trunc = v;
    endcase
  endfunction : trunc

  function automatic logic [3:0] slot_of(input osz_t s);
    case (s)
      OSZ_16: slot_of = SLOT_16;
      OSZ_32: slot_of = SLOT_32;
      default: slot_of = SLOT_64;
    endcase
  endfunction : slot_of

  function automatic logic [STK_AW-1:0] addr_of(input logic [63:0] p);
    addr_of = p[STK_AW:1];
  endfunction : addr_of

  function automatic logic [1:0] ring_of(input logic [15:0] sel);
    ring_of = sel[SEL_RING_LSB+:2];
  endfunction : ring_of

  // ==========================================================================
  // state
  state_t st_q;
  op_t op_q;
  logic [63:0] gpr_q [NUM_GPR];
  logic [63:0] ip_q;
  logic [15:0] cs_q;
  logic [15:0] ss_q;
  logic [1:0] cpl_q;
  logic [31:0] flags_q;
  logic [2:0] idx_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] slot_q;
  logic [63:0] ptr_q;
  logic [63:0] src_q;
  logic [63:0] old_sp_q;
  logic [63:0] old_ip_q;
  logic [15:0] old_ss_q;
  logic [15:0] old_cs_q;
  logic [63:0] tgt_ip_q;
  logic [15:0] tgt_cs_q;
  logic [15:0] tgt_ss_q;
  logic [1:0] tgt_ring_q;
  logic [15:0] n_q;
  logic [63:0] cnt_next_q;
  logic done_q;
  logic fault_q;

  logic mem_we;
  logic [STK_AW-1:0] mem_addr;
  logic [63:0] mem_wdata;
  logic [63:0] mem_rdata;

  // ==========================================================================
  // command decode
  osz_t eff_osz;
  logic [3:0] eff_slot;
  logic [63:0] sp_now;
  logic [63:0] rel_tgt;
  logic [63:0] br_tgt;
  logic [63:0] cnt_masked;
  logic [1:0] gate_ring;
  logic gate_fmt_ok;
  logic take;
  logic [63:0] slot_ext;

  assign take = i_cmd_valid && (st_q == ST_IDLE);
  assign sp_now = gpr_q[GPR_SP];
  assign slot_ext = {60'h0, slot_q};
  // prefix is ignored in 64-bit mode
  assign eff_osz = i_mode64 ? OSZ_64 : (i_cmd.osz16 ? OSZ_16 : OSZ_32);
  assign eff_slot = slot_of(eff_osz);
  // displacement is only ever 32 bits, sign-extended
  assign rel_tgt = trunc(ip_q + {{32{i_cmd.disp[31]}}, i_cmd.disp}, eff_osz);
  assign br_tgt = i_cmd.indirect ? trunc(i_cmd.value, eff_osz) : rel_tgt;
  // count width follows address size, never forced by the branch
  always_comb begin
    if (i_cmd.asz32) begin
      cnt_masked = {32'h0, gpr_q[1][31:0]};
    end else if (i_mode64) begin
      cnt_masked = gpr_q[1];
    end else begin
      cnt_masked = {48'h0, gpr_q[1][15:0]};
    end
  end
  assign gate_ring = ring_of(i_gate.cs_sel);
  assign gate_fmt_ok = i_gate.wide ? (i_mode64 || i_compat) : !i_mode64;

  // ==========================================================================
  // stack memory port
  always_comb begin
    mem_we = 1'b0;
    mem_addr = addr_of(ptr_q - slot_ext);
    mem_wdata = 64'h0;
    case (st_q)
      ST_IDLE: begin
        mem_addr = addr_of(sp_now - {60'h0, eff_slot});
        mem_wdata = ip_q;
        if (take && (i_cmd.op == OP_CALL_NEAR)) begin
          mem_we = 1'b1;
        end
        if (take && (i_cmd.op == OP_PUSH_FLAGS_WORD_W)) begin
          mem_we = 1'b1;
          mem_addr = addr_of(sp_now - {60'h0, SLOT_16});
          mem_wdata = {48'h0, flags_q[15:0]};
        end
        if (take && (i_cmd.op == OP_PUSH_FLAGS_WORD_D)) begin
          mem_we = 1'b1;
          mem_addr = addr_of(sp_now - {60'h0, SLOT_32});
          mem_wdata = {32'h0, flags_q};
        end
      end
      ST_PUSH_ALL: begin
        mem_we = 1'b1;
        mem_wdata = (idx_q == GPR_SP) ? old_sp_q : gpr_q[idx_q];
      end
      ST_POP_RD: mem_addr = addr_of(ptr_q);
      ST_G_STK: begin
        mem_we = 1'b1;
        mem_wdata = (idx_q == 3'h0) ? {48'h0, old_ss_q} : old_sp_q;
      end
      ST_G_CPRD: mem_addr = addr_of(src_q - slot_ext);
      ST_G_CPWR: begin
        mem_we = 1'b1;
        mem_wdata = mem_rdata;
      end
      ST_G_LINK: begin
        mem_we = 1'b1;
        mem_wdata = (idx_q == 3'h0) ? {48'h0, old_cs_q} : old_ip_q;
      end
      default: mem_we = 1'b0;
    endcase
  end

  stack_ram #(
    .AW(STK_AW),
    .DW(XLEN)
  ) u_stack_ram (
    .i_sys_clk(i_sys_clk),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // ==========================================================================
  // sequencer; except pop-all, which writes each register but si and sp as it is read, architectural state changes only in the last step,
  // so a fault mid-sequence leaves nothing half written
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q <= ST_IDLE;
      op_q <= OP_NOP;
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_q[i] <= 64'h0;
      end
      ip_q <= RST_IP;
      cs_q <= RST_CS;
      ss_q <= RST_SS;
      cpl_q <= RST_CPL;
      flags_q <= RST_FLAGS;
      idx_q <= 3'h0;
      cnt_q <= '0;
      slot_q <= SLOT_32;
      ptr_q <= RST_SP;
      src_q <= 64'h0;
      old_sp_q <= 64'h0;
      old_ip_q <= 64'h0;
      old_ss_q <= 16'h0;
      old_cs_q <= 16'h0;
      tgt_ip_q <= 64'h0;
      tgt_cs_q <= 16'h0;
      tgt_ss_q <= 16'h0;
      tgt_ring_q <= 2'h0;
      n_q <= 16'h0;
      cnt_next_q <= 64'h0;
      gpr_q[GPR_SP] <= RST_SP;
    end else if (i_ce) begin
      case (st_q)
        ST_IDLE: begin
          op_q <= i_cmd.op;
          slot_q <= eff_slot;
          ptr_q <= sp_now;
          old_sp_q <= sp_now;
          old_ss_q <= ss_q;
          old_cs_q <= cs_q;
          old_ip_q <= ip_q;
          n_q <= i_cmd.n;
          idx_q <= 3'h0;
          tgt_ss_q <= ss_q;
          tgt_ring_q <= cpl_q;
          // no flag, and no register but ip, cs and, on a ring switch, ss and sp, is saved by any call
          if (take) begin
            case (i_cmd.op)
              OP_SET_GPR: gpr_q[i_cmd.idx] <= i_cmd.value;
              OP_PUSH_ALL: st_q <= ST_PUSH_ALL;
              OP_POP_ALL, OP_RET_NEAR, OP_RET_FAR: st_q <= ST_POP_RD;
              OP_POP_FLAGS_WORD_W: begin
                slot_q <= SLOT_16;
                st_q <= ST_POP_RD;
              end
              OP_POP_FLAGS_WORD_D: begin
                slot_q <= SLOT_32;
                st_q <= ST_POP_RD;
              end
              OP_PUSH_FLAGS_WORD_W: gpr_q[GPR_SP] <= sp_now - {60'h0, SLOT_16};
              OP_PUSH_FLAGS_WORD_D: gpr_q[GPR_SP] <= sp_now - {60'h0, SLOT_32};
              OP_CALL_NEAR: begin
                gpr_q[GPR_SP] <= sp_now - {60'h0, eff_slot};
                ip_q <= br_tgt;
              end
              OP_JMP: ip_q <= br_tgt;
              OP_JCC: begin
                if (i_cmd.cond_zero) begin
                  ip_q <= br_tgt;
                end
              end
              OP_LOOP: begin
                cnt_next_q <= cnt_masked - 64'h1;
                st_q <= i_cmd.cond_zero ? ST_JUMP_IF_COUNT_ZERO : ST_COMMIT;
                tgt_ip_q <= br_tgt;
              end
              OP_CALL_FAR: begin
                tgt_cs_q <= i_cmd.sel;
                tgt_ip_q <= trunc(i_cmd.value, eff_osz);
                // no gate: only the current ring may be entered
                st_q <= (ring_of(i_cmd.sel) == cpl_q) ? ST_G_LINK : ST_FAULT;
              end
              OP_CALL_GATE: begin
                tgt_cs_q <= i_gate.cs_sel;
                tgt_ip_q <= i_gate.wide ? i_gate.offset : {32'h0, i_gate.offset[31:0]};
                tgt_ring_q <= gate_ring;
                slot_q <= i_gate.wide ? SLOT_64 : SLOT_32;
                cnt_q <= i_gate.pcount;
                // rights checked before anything is latched into use
                if (!gate_fmt_ok || (cpl_q > i_gate.dpl) || (gate_ring > cpl_q)) begin
                  st_q <= ST_FAULT;
                end else if (gate_ring == cpl_q) begin
                  st_q <= ST_G_LINK;
                end else begin
                  ptr_q <= i_tss_stk[gate_ring].sp;
                  tgt_ss_q <= i_tss_stk[gate_ring].ss;
                  src_q <= sp_now + ({59'h0, i_gate.pcount} << (i_gate.wide ? 3 : 2));
                  st_q <= ST_G_STK;
                end
              end
              default: st_q <= ST_IDLE;
            endcase
          end
        end
        ST_JUMP_IF_COUNT_ZERO: begin
          // loop without count-zero test falls to commit; this is jump-if-count-zero
          if (cnt_masked == 64'h0) begin
            ip_q <= tgt_ip_q;
          end
          st_q <= ST_IDLE;
        end
        ST_PUSH_ALL: begin
          ptr_q <= ptr_q - slot_ext;
          idx_q <= idx_q + 3'h1;
          if (idx_q == GPR_LAST) begin
            gpr_q[GPR_SP] <= ptr_q - slot_ext;
            st_q <= ST_IDLE;
          end
        end
        ST_POP_RD: st_q <= ST_POP_WB;
        ST_POP_WB: begin
          ptr_q <= ptr_q + slot_ext;
          idx_q <= idx_q + 3'h1;
          st_q <= ST_POP_RD;
          case (op_q)
            OP_POP_ALL: begin
              // the saved stack-pointer slot equals the final pointer anyway
              if ((GPR_LAST - idx_q) != GPR_SI && (GPR_LAST - idx_q) != GPR_SP) begin
                gpr_q[GPR_LAST - idx_q] <= mem_rdata;
              end
              if (idx_q == GPR_LAST) begin
                gpr_q[GPR_SP] <= ptr_q + slot_ext;
                st_q <= ST_IDLE;
              end
            end
            OP_POP_FLAGS_WORD_W: begin
              flags_q[15:0] <= mem_rdata[15:0] & FLAGS_LO_MASK;
              gpr_q[GPR_SP] <= ptr_q + slot_ext;
              st_q <= ST_IDLE;
            end
            OP_POP_FLAGS_WORD_D: begin
              flags_q <= mem_rdata[31:0];
              gpr_q[GPR_SP] <= ptr_q + slot_ext;
              st_q <= ST_IDLE;
            end
            OP_RET_NEAR: begin
              ip_q <= trunc(mem_rdata, eff_osz);
              gpr_q[GPR_SP] <= ptr_q + slot_ext + {48'h0, n_q};
              st_q <= ST_IDLE;
            end
            default: begin
              // far return: ip, selector, then outer sp and ss
              case (idx_q)
                3'h0: tgt_ip_q <= mem_rdata;
                3'h1: begin
                  tgt_cs_q <= mem_rdata[15:0];
                  tgt_ring_q <= ring_of(mem_rdata[15:0]);
                  ptr_q <= ptr_q + slot_ext + {48'h0, n_q};
                  if (ring_of(mem_rdata[15:0]) < cpl_q) begin
                    st_q <= ST_FAULT;
                  end else if (ring_of(mem_rdata[15:0]) == cpl_q) begin
                    st_q <= ST_COMMIT;
                  end
                end
                3'h2: old_sp_q <= mem_rdata + {48'h0, n_q};
                default: begin
                  tgt_ss_q <= mem_rdata[15:0];
                  ptr_q <= old_sp_q;
                  st_q <= ST_COMMIT;
                end
              endcase
            end
          endcase
        end
        ST_G_STK: begin
          ptr_q <= ptr_q - slot_ext;
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'h1) begin
            idx_q <= 3'h0;
            st_q <= (cnt_q == '0) ? ST_G_LINK : ST_G_CPRD;
          end
        end
        ST_G_CPRD: begin
          src_q <= src_q - slot_ext;
          st_q <= ST_G_CPWR;
        end
        ST_G_CPWR: begin
          ptr_q <= ptr_q - slot_ext;
          cnt_q <= cnt_q - 1'b1;
          st_q <= (cnt_q == CNT_W'(1)) ? ST_G_LINK : ST_G_CPRD;
        end
        ST_G_LINK: begin
          ptr_q <= ptr_q - slot_ext;
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'h1) begin
            ptr_q <= ptr_q - slot_ext;
            st_q <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          st_q <= ST_IDLE;
          if (op_q == OP_LOOP) begin
            gpr_q[1] <= cnt_next_q;
            if (cnt_next_q != 64'h0) begin
              ip_q <= tgt_ip_q;
            end
          end else begin
            cs_q <= tgt_cs_q;
            ip_q <= tgt_ip_q;
            ss_q <= tgt_ss_q;
            cpl_q <= tgt_ring_q;
            gpr_q[GPR_SP] <= ptr_q;
          end
        end
        ST_FAULT: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // completion and fault pulses
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (i_ce) begin
      fault_q <= (st_q == ST_FAULT);
      done_q <= (st_q != ST_IDLE) && (st_q != ST_FAULT) && (st_q != ST_POP_RD) &&
                ((st_q == ST_COMMIT) || (st_q == ST_JUMP_IF_COUNT_ZERO) ||
                 ((st_q == ST_PUSH_ALL) && (idx_q == GPR_LAST)) ||
                 ((st_q == ST_POP_WB) && (op_q != OP_RET_FAR) &&
                  ((op_q != OP_POP_ALL) || (idx_q == GPR_LAST))));
    end
  end

  assign o_ready = st_q[0];
  assign o_done = done_q;
  assign o_gp_fault = fault_q;
  assign o_ip = ip_q;
  assign o_cs = cs_q;
  assign o_ss = ss_q;
  assign o_cpl = cpl_q;
  assign o_flags = flags_q;
  always_comb begin
    for (int i = 0; i < NUM_GPR; i++) begin
      o_gpr[i] = gpr_q[i];
    end
  end
endmodule : procedure_call_privilege_sequencer

// ---- src/stack_ram.sv ----
// file: single-port stack memory with registered read data
`timescale 1ns/100ps
module stack_ram #(
  parameter int AW = 10,
  parameter int DW = 64
) (
  input wire logic i_sys_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  // no reset: contents are software data, only read after written
  always_ff @(posedge i_sys_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
    end
  end
endmodule : stack_ram

// ---- verification/call_seq_sva.sv ----
// checker: port-level properties of the procedure call sequencer
`timescale 1ns/100ps
module call_seq_sva (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire call_seq_pkg::cmd_t i_cmd,
  input wire call_seq_pkg::gate_t i_gate,
  input wire logic i_mode64,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_gp_fault,
  input wire logic [63:0] o_ip,
  input wire logic [15:0] o_cs,
  input wire logic [15:0] o_ss,
  input wire logic [1:0] o_cpl,
  input wire logic [31:0] o_flags,
  input wire logic [7:0][63:0] o_gpr
);
  import call_seq_pkg::*;
  // ==========================================================================
  // common terms
  logic take;
  assign take = i_ce && o_ready && i_cmd_valid;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ==========================================================================
  // properties
  a_done_single: assert property (o_done |=> !o_done)
    else $error("completion pulse longer than one cycle");
  a_fault_single: assert property (o_gp_fault |=> !o_gp_fault)
    else $error("fault pulse longer than one cycle");
  a_fault_no_change: assert property (o_gp_fault |-> o_ip == $past(o_ip, 2) && o_cs == $past(o_cs, 2)
    && o_ss == $past(o_ss, 2) && o_cpl == $past(o_cpl, 2) && o_gpr[4] == $past(o_gpr[4], 2))
    else $error("faulting operation changed state");
  a_gate_refused: assert property (take && i_cmd.op == OP_CALL_GATE && i_gate.dpl < o_cpl |-> ##[1:3] o_gp_fault)
    else $error("gate without rights not refused");
  a_push_all_time: assert property (take && i_cmd.op == OP_PUSH_ALL |-> ##[8:10] o_done)
    else $error("push of all registers not completed in time");
  a_push_flags_word_dword: assert property (take && i_cmd.op == OP_PUSH_FLAGS_WORD_D && !i_mode64 && !i_cmd.osz16
    |=> o_gpr[4] == $past(o_gpr[4]) - 64'h0000_0000_0000_0004)
    else $error("dword flag push moved stack wrongly");
  a_near_wide: assert property (take && i_cmd.op == OP_CALL_NEAR && i_mode64
    |=> o_gpr[4] == $past(o_gpr[4]) - 64'h0000_0000_0000_0008)
    else $error("near call in wide mode not 8 bytes");
  a_jmp_indirect: assert property (take && i_cmd.op == OP_JMP && i_cmd.indirect && i_mode64
    |=> o_ip == $past(i_cmd.value))
    else $error("indirect jump target not full width");
  a_call_keeps_regs: assert property (take && i_cmd.op == OP_CALL_NEAR |=> $stable(o_flags)
    && o_gpr[3:0] == $past(o_gpr[3:0]) && o_gpr[7:5] == $past(o_gpr[7:5]))
    else $error("call altered registers or flags");
endmodule : call_seq_sva

// ---- verification/tb_top.sv ----
// testbench: directed scenarios for the procedure call sequencer
`timescale 1ns/100ps
module tb_top;
  import call_seq_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic i_mode64 = 1'b0;
  logic i_compat = 1'b0;
  cmd_t i_cmd = '0;
  gate_t i_gate = '0;
  stk_ptr_t [2:0] i_tss_stk = '0;
  logic o_ready;
  logic o_done;
  logic o_gp_fault;
  logic [63:0] o_ip;
  logic [15:0] o_cs;
  logic [15:0] o_ss;
  logic [1:0] o_cpl;
  logic [31:0] o_flags;
  logic [7:0][63:0] o_gpr;
  logic flt;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  procedure_call_privilege_sequencer DUT (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_gate(i_gate), .i_tss_stk(i_tss_stk), .i_mode64(i_mode64), .i_compat(i_compat),
    .o_ready(o_ready), .o_done(o_done), .o_gp_fault(o_gp_fault), .o_ip(o_ip), .o_cs(o_cs),
    .o_ss(o_ss), .o_cpl(o_cpl), .o_flags(o_flags), .o_gpr(o_gpr)
  );
  // the whole run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic results();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_rst();
    i_srst = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    i_srst = 1'b0;
  endtask : do_rst
  function automatic cmd_t mk(input op_t op, input logic [63:0] v);
    cmd_t c;
    c = '0;
    c.op = op;
    c.value = v;
    return c;
  endfunction : mk
  // request held one full cycle, then optionally wait for done or fault
  task automatic send(input cmd_t c, input bit wait_end);
    int k;
    k = 0;
    // one idle edge between requests so valid is never rewritten in one step
    @(negedge i_sys_clk);
    while (o_ready !== 1'b1 && k < 100) begin
      @(negedge i_sys_clk);
      k++;
    end
    i_cmd = c;
    i_cmd_valid = 1'b1;
    @(negedge i_sys_clk);
    i_cmd_valid = 1'b0;
    k = 0;
    while (wait_end && o_done !== 1'b1 && o_gp_fault !== 1'b1 && k < 100) begin
      @(negedge i_sys_clk);
      k++;
    end
    flt = o_gp_fault;
    if (k >= 100) chk(64'h0, 64'h1);
  endtask : send
  task automatic setg(input logic [2:0] idx, input logic [63:0] v);
    cmd_t c;
    c = mk(OP_SET_GPR, v);
    c.idx = idx;
    send(c, 1'b0);
  endtask : setg
  // ==========================================================================
  // scenarios
  task automatic t_stack();
    logic [63:0] v [8];
    do_rst();
    for (int i = 0; i < 8; i++) begin
      v[i] = 64'h0000_0000_0000_0102 | (64'(i) << 16);
      if (i != 4) setg(3'(i), v[i]);
    end
    setg(GPR_SP, 64'h0000_0000_0000_0200);
    send(mk(OP_PUSH_ALL, '0), 1'b1);
    chk(o_gpr[4], 64'h0000_0000_0000_01e0);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) setg(3'(i), ~v[i]);
    end
    send(mk(OP_POP_ALL, '0), 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) chk(o_gpr[i], (i == 6) ? ~v[i] : v[i]);
    end
    chk(o_gpr[4], 64'h0000_0000_0000_0200);
    send(mk(OP_PUSH_ALL, '0), 1'b1);
    send(mk(OP_POP_FLAGS_WORD_D, '0), 1'b1);
    chk(64'(o_flags), {32'h0000_0000, v[7][31:0]});
    setg(GPR_LAST, 64'h0000_0000_0000_5a5a);
    send(mk(OP_PUSH_ALL, '0), 1'b1);
    send(mk(OP_POP_FLAGS_WORD_W, '0), 1'b1);
    chk(64'(o_flags), 64'h0000_0000_0007_5a5a);
    send(mk(OP_PUSH_FLAGS_WORD_W, '0), 1'b0);
    chk(o_gpr[4], 64'h0000_0000_0000_01c4);
    send(mk(OP_PUSH_FLAGS_WORD_D, '0), 1'b0);
    chk(o_gpr[4], 64'h0000_0000_0000_01c0);
    send(mk(OP_POP_FLAGS_WORD_D, '0), 1'b1);
    chk(64'(o_flags), 64'h0000_0000_0007_5a5a);
    // let the completion pulse drop before freezing, or it would stand
    @(negedge i_sys_clk);
    i_ce = 1'b0;
    send(mk(OP_PUSH_FLAGS_WORD_D, '0), 1'b0);
    i_ce = 1'b1;
    chk(o_gpr[4], 64'h0000_0000_0000_01c4);
  endtask : t_stack
  task automatic t_near();
    cmd_t c;
    do_rst();
    i_mode64 = 1'b1;
    c = mk(OP_CALL_NEAR, '0);
    c.osz16 = 1'b1;
    c.disp = 32'h0000_0040;
    send(c, 1'b0);
    chk(o_gpr[4], 64'h0000_0000_0000_03f8);
    chk(o_ip, 64'h0000_0000_0000_0040);
    c = mk(OP_RET_NEAR, '0);
    c.osz16 = 1'b1;
    c.n = 16'h0010;
    send(c, 1'b1);
    chk(o_ip, 64'h0000_0000_0000_0000);
    chk(o_gpr[4], 64'h0000_0000_0000_0410);
    c = mk(OP_JMP, 64'h1234_5678_9abc_def0);
    c.indirect = 1'b1;
    c.osz16 = 1'b1;
    send(c, 1'b0);
    chk(o_ip, 64'h1234_5678_9abc_def0);
    c = mk(OP_JMP, '0);
    c.disp = 32'hffff_fff0;
    send(c, 1'b0);
    chk(o_ip, 64'h1234_5678_9abc_dee0);
    i_mode64 = 1'b0;
  endtask : t_near
  task automatic t_far();
    cmd_t c;
    do_rst();
    c = mk(OP_CALL_FAR, 64'h0000_0000_0000_5000);
    c.sel = 16'h0013;
    send(c, 1'b1);
    chk(64'(o_cs), 64'h0000_0000_0000_0013);
    chk(o_ip, 64'h0000_0000_0000_5000);
    chk(o_gpr[4], 64'h0000_0000_0000_03f8);
    c = mk(OP_RET_FAR, '0);
    c.n = 16'h0008;
    send(c, 1'b1);
    chk(64'(o_cs), 64'h0000_0000_0000_0003);
    chk(o_gpr[4], 64'h0000_0000_0000_0408);
  endtask : t_far
  task automatic t_gate();
    cmd_t c;
    i_gate.dpl = 2'h3;
    i_gate.offset = 64'h0000_0000_0000_8000;
    i_gate.pcount = 5'h02;
    for (int r = 0; r < 3; r++) begin
      do_rst();
      i_tss_stk[r].ss = 16'h0010 | 16'(r);
      i_tss_stk[r].sp = 64'h0000_0000_0000_0300;
      i_gate.cs_sel = 16'h0008 | 16'(r);
      setg(GPR_ACC, 64'h0000_0000_0000_0077);
      c = mk(OP_CALL_GATE, '0);
      c.sel = 16'h0023;
      send(c, 1'b1);
      chk(64'(flt), 64'h0);
      chk(64'(o_cs), 64'h0008 | 64'(r));
      chk(o_ip, 64'h0000_0000_0000_8000);
      chk(64'(o_ss), 64'h0010 | 64'(r));
      chk(64'(o_cpl), 64'(r));
      chk(o_gpr[4], 64'h0000_0000_0000_02e8);
      chk(o_gpr[0], 64'h0000_0000_0000_0077);
      c = mk(OP_RET_FAR, '0);
      c.n = 16'h0008;
      send(c, 1'b1);
      chk(64'(o_cs), 64'h0000_0000_0000_0003);
      chk(64'(o_ss), 64'h0000_0000_0000_000b);
      chk(64'(o_cpl), 64'h0000_0000_0000_0003);
      chk(o_gpr[4], 64'h0000_0000_0000_0408);
    end
    do_rst();
    i_gate.dpl = 2'h0;
    send(c_gate(), 1'b1);
    chk(64'(flt), 64'h1);
    chk(o_gpr[4] ^ 64'(o_cs) ^ o_ip, 64'h0000_0000_0000_0403);
    chk(64'(o_cpl), 64'h0000_0000_0000_0003);
    i_gate.dpl = 2'h3;
    i_gate.wide = 1'b1;
    i_gate.pcount = 5'h00;
    for (int k = 0; k < 2; k++) begin
      do_rst();
      i_mode64 = k[0];
      i_compat = !k[0];
      send(c_gate(), 1'b1);
      chk(64'(flt), 64'h0);
      chk(o_gpr[4], 64'h0000_0000_0000_02e0);
    end
    i_mode64 = 1'b0;
    i_compat = 1'b0;
  endtask : t_gate
  task automatic t_loop();
    cmd_t c;
    do_rst();
    setg(3'h1, 64'h0000_0000_0000_0002);
    c = mk(OP_LOOP, '0);
    c.disp = 32'h0000_0020;
    send(c, 1'b1);
    chk(o_gpr[1], 64'h0000_0000_0000_0001);
    chk(o_ip, 64'h0000_0000_0000_0020);
    c.op = OP_JCC;
    c.cond_zero = 1'b1;
    send(c, 1'b0);
    chk(o_ip, 64'h0000_0000_0000_0040);
    c.op = OP_LOOP;
    send(c, 1'b1);
    chk(o_ip, 64'h0000_0000_0000_0040);
  endtask : t_loop
  function automatic cmd_t c_gate();
    cmd_t c;
    c = mk(OP_CALL_GATE, '0);
    c.sel = 16'h0023;
    return c;
  endfunction : c_gate
  initial begin
    do_rst();
    t_stack();
    t_near();
    t_far();
    t_loop();
    t_gate();
    results();
  end
endmodule : tb_top
bind procedure_call_privilege_sequencer call_seq_sva u_sva (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .i_gate(i_gate), .i_mode64(i_mode64), .o_ready(o_ready), .o_done(o_done), .o_gp_fault(o_gp_fault),
  .o_ip(o_ip), .o_cs(o_cs), .o_ss(o_ss), .o_cpl(o_cpl), .o_flags(o_flags), .o_gpr(o_gpr)
);
